// File: hw/crbd_pkg.sv
// Package for the receive buffer dispatch block: register map, field positions, types.
// Assumes a single 200 MHz system clock domain; no timing counts are needed.
package crbd_pkg;

	// Register byte addresses
	localparam logic [7:0] ADDR_PIN_CTRL = 8'h0c;
	localparam logic [7:0] ADDR_CTRL0 = 8'h60;
	localparam logic [7:0] ADDR_CTRL1 = 8'h70;

	// Pin control fields
	localparam int PC_LVL_LSB = 4;
	localparam int PC_ENA_LSB = 2;
	localparam int PC_MODE_LSB = 0;

	// Buffer control fields
	localparam int CTL_FMODE_LSB = 5;
	localparam int CTL_RTR_BIT = 3;
	localparam int CTL_ROLL_BIT = 2;
	localparam int CTL_ROLL_COPY_BIT = 1;
	localparam int CTL_HIT_LSB = 0;

	// Receive filter mode: masks and filters off
	localparam logic [1:0] FMODE_ANY = 2'h3;
	// Upper hit bits of a rolled-over message in the second buffer
	localparam logic [1:0] ROLL_HIT_HI = 2'h0;

	// Controller status low nibble after a load
	localparam logic [3:0] STAT_NONE = 4'h0;
	localparam logic [3:0] STAT_BUF0 = 4'h6;
	localparam logic [3:0] STAT_BUF1 = 4'h7;

	typedef enum logic [0:0] {
		PH_IDLE = 1'b0,
		PH_ASM = 1'b1
	} crbd_phase_t;

	typedef struct packed {
		crbd_phase_t state;
		logic [1:0] rxm0;
		logic rtr0;
		logic roll_en;
		logic hit0;
		logic [1:0] rxm1;
		logic rtr1;
		logic [2:0] hit1;
		logic [1:0] pin_lvl;
		logic [1:0] pin_ena;
		logic [1:0] pin_mode;
		logic [1:0] rxif;
		logic [1:0] ovr;
		logic [3:0] stat;
		logic int_n;
		logic [1:0] load;
		logic msg_err;
		logic [7:0] rdata;
	} crbd_state_t;

	typedef struct packed {
		logic [1:0] o;
		logic [1:0] oe;
	} crbd_pin_state_t;

endpackage

// File: hw/crbd_pin_if.sv
// Interface carrying pin configuration and receive flags to the buffer-full pin driver.
// Assumes both ends sit on sys_clk.
`timescale 1ns/10ps
`default_nettype none
interface crbd_pin_if;
	logic [1:0] ena;
	logic [1:0] mode;
	logic [1:0] lvl;
	logic [1:0] flag;
	modport ctl (output ena, output mode, output lvl, output flag);
	modport drv (input ena, input mode, input lvl, input flag);
endinterface
`default_nettype wire

// File: hw/crbd_pin_drv.sv
// Buffer-full pin driver: disabled, active-low interrupt or plain output per pin.
// Assumes configuration and flags arrive registered on sys_clk.
`timescale 1ns/10ps
`default_nettype none
module crbd_pin_drv (
	input wire logic sys_clk,
	input wire logic rst,
	crbd_pin_if.drv cfg,
	output logic [1:0] pin_o,
	output logic [1:0] pin_oe
);
	import crbd_pkg::*;

	crbd_pin_state_t s_q;
	crbd_pin_state_t s_d;
	logic [1:0] o_d;
	logic [1:0] oe_d;

	genvar i;
	generate
		for (i = 0; i < 2; i++) begin : g_pin
			assign oe_d[i] = cfg.ena[i];
			assign o_d[i] = cfg.mode[i] ? ~cfg.flag[i] : cfg.lvl[i];
		end
	endgenerate

	always_comb begin
		s_d.o = o_d;
		s_d.oe = oe_d;
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign pin_o = s_q.o;
	assign pin_oe = s_q.oe;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	property p_pin_release;
		!cfg.ena[0] |=> !pin_oe[0];
	endproperty
	a_pin_release: assert property (p_pin_release) else $error("pin 0 not released");

	property p_pin_irq;
		cfg.ena[1] && cfg.mode[1] |=> pin_oe[1] && (pin_o[1] == !$past(cfg.flag[1]));
	endproperty
	a_pin_irq: assert property (p_pin_irq) else $error("pin 1 not following flag");

	property p_pin_out;
		cfg.ena[0] && !cfg.mode[0] |=> pin_oe[0] && (pin_o[0] == $past(cfg.lvl[0]));
	endproperty
	a_pin_out: assert property (p_pin_out) else $error("pin 0 level wrong");
endmodule
`default_nettype wire

// File: hw/crbd_top.sv
// Receive dispatch: moves an accepted message into one of two receive buffers,
// keeps flags, filter-hit and remote bits, interrupt output and buffer-full pins.
// Assumes filter matching, buffer storage and the register port logic run on sys_clk.
`timescale 1ns/10ps
`default_nettype none
module crbd_top (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_wmask,
	output logic [7:0] reg_rdata,
	input wire logic msg_start,
	input wire logic msg_end,
	input wire logic msg_valid,
	input wire logic msg_rtr,
	input wire logic flt0_match,
	input wire logic flt0_idx,
	input wire logic flt1_match,
	input wire logic [2:0] flt1_idx,
	input wire logic [1:0] rx_flag_clear,
	input wire logic [1:0] ovr_flag_clear,
	input wire logic [1:0] receive_irq_enable,
	input wire logic error_irq_enable,
	output logic [1:0] receive_flag,
	output logic [1:0] overflow_flag,
	output logic [3:0] controller_status,
	output logic int_n,
	output logic [1:0] buf_load,
	output logic msg_error,
	output logic [1:0] buf_full_pin_o,
	output logic [1:0] buf_full_pin_oe
);
	import crbd_pkg::*;

	crbd_state_t s_q;
	crbd_state_t s_d;
	crbd_pin_if pin_bus();

	logic go;
	logic acc0;
	logic acc1;
	logic to0;
	logic to1;
	logic [2:0] hit1_new;
	logic [7:0] pc_cur;
	logic [7:0] c0_cur;
	logic [7:0] c1_cur;
	logic [7:0] wr_new;
	logic [1:0] irq_mode;

	assign irq_mode = s_q.pin_ena & s_q.pin_mode;

	// Register images as stored; pin control keeps raw state bits for bit-modify
	always_comb begin
		pc_cur = '0;
		pc_cur[PC_LVL_LSB +: 2] = s_q.pin_lvl;
		pc_cur[PC_ENA_LSB +: 2] = s_q.pin_ena;
		pc_cur[PC_MODE_LSB +: 2] = s_q.pin_mode;
		c0_cur = '0;
		c0_cur[CTL_FMODE_LSB +: 2] = s_q.rxm0;
		c0_cur[CTL_RTR_BIT] = s_q.rtr0;
		c0_cur[CTL_ROLL_BIT] = s_q.roll_en;
		c0_cur[CTL_ROLL_COPY_BIT] = s_q.roll_en;
		c0_cur[CTL_HIT_LSB] = s_q.hit0;
		c1_cur = '0;
		c1_cur[CTL_FMODE_LSB +: 2] = s_q.rxm1;
		c1_cur[CTL_RTR_BIT] = s_q.rtr1;
		c1_cur[CTL_HIT_LSB +: 3] = s_q.hit1;
	end

	// Dispatch decision for a message finishing assembly
	always_comb begin
		go = (s_q.state == PH_ASM) && msg_end && msg_valid;
		acc0 = (s_q.rxm0 == FMODE_ANY) || flt0_match;
		acc1 = (s_q.rxm1 == FMODE_ANY) || flt1_match;
		to0 = go && acc0 && !s_q.rxif[0];
		to1 = go && ((acc0 && s_q.rxif[0] && s_q.roll_en) || (!acc0 && acc1));
		hit1_new = acc0 ? {ROLL_HIT_HI, flt0_idx} : flt1_idx;
	end

	always_comb begin
		s_d = s_q;
		s_d.load = '0;
		s_d.msg_err = 1'b0;
		wr_new = '0;
		case (s_q.state)
			PH_IDLE: begin
				if (msg_start) begin
					s_d.state = PH_ASM;
				end
			end
			PH_ASM: begin
				if (msg_end) begin
					s_d.state = PH_IDLE;
					s_d.msg_err = !msg_valid;
				end
			end
			default: begin
				s_d.state = PH_IDLE;
			end
		endcase

		// Host clears first so that a set in the same cycle wins
		s_d.rxif = s_q.rxif & ~rx_flag_clear;
		s_d.ovr = s_q.ovr & ~ovr_flag_clear;

		if (to0) begin
			s_d.rxif[0] = 1'b1;
			s_d.hit0 = flt0_idx;
			s_d.rtr0 = msg_rtr;
			s_d.load[0] = 1'b1;
			s_d.stat = STAT_BUF0;
		end
		if (go && acc0 && s_q.rxif[0] && !s_q.roll_en) begin
			s_d.ovr[0] = 1'b1;
		end
		if (to1) begin
			if (s_q.rxif[1]) begin
				s_d.ovr[1] = 1'b1;
			end else begin
				s_d.rxif[1] = 1'b1;
				s_d.hit1 = hit1_new;
				s_d.rtr1 = msg_rtr;
				if (acc0) begin
					s_d.hit0 = flt0_idx;
				end
				s_d.load[1] = 1'b1;
				s_d.stat = STAT_BUF1;
			end
		end

		// Register writes; a plain write passes an all-ones mask
		if (reg_wr) begin
			case (reg_addr)
				ADDR_PIN_CTRL: begin
					wr_new = (pc_cur & ~reg_wmask) | (reg_wdata & reg_wmask);
					s_d.pin_lvl = wr_new[PC_LVL_LSB +: 2];
					s_d.pin_ena = wr_new[PC_ENA_LSB +: 2];
					s_d.pin_mode = wr_new[PC_MODE_LSB +: 2];
				end
				ADDR_CTRL0: begin
					wr_new = (c0_cur & ~reg_wmask) | (reg_wdata & reg_wmask);
					s_d.rxm0 = wr_new[CTL_FMODE_LSB +: 2];
					s_d.roll_en = wr_new[CTL_ROLL_BIT];
				end
				ADDR_CTRL1: begin
					wr_new = (c1_cur & ~reg_wmask) | (reg_wdata & reg_wmask);
					s_d.rxm1 = wr_new[CTL_FMODE_LSB +: 2];
				end
				default: begin
					wr_new = '0;
				end
			endcase
		end

		// Active-low interrupt tracks the enabled flags as they will stand
		s_d.int_n = !(|(s_d.rxif & receive_irq_enable) ||
			(|s_d.ovr && error_irq_enable));

		s_d.rdata = '0;
		if (reg_rd) begin
			case (reg_addr)
				ADDR_PIN_CTRL: begin
					s_d.rdata = pc_cur;
					s_d.rdata[PC_LVL_LSB +: 2] = s_q.pin_lvl & ~irq_mode;
				end
				ADDR_CTRL0: begin
					s_d.rdata = c0_cur;
				end
				ADDR_CTRL1: begin
					s_d.rdata = c1_cur;
				end
				default: begin
					s_d.rdata = '0;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			s_q <= '0;
			s_q.int_n <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign pin_bus.ena = s_q.pin_ena;
	assign pin_bus.mode = s_q.pin_mode;
	assign pin_bus.lvl = s_q.pin_lvl;
	assign pin_bus.flag = s_q.rxif;

	crbd_pin_drv u_pins (
		.sys_clk(sys_clk),
		.rst(rst),
		.cfg(pin_bus.drv),
		.pin_o(buf_full_pin_o),
		.pin_oe(buf_full_pin_oe)
	);

	assign reg_rdata = s_q.rdata;
	assign receive_flag = s_q.rxif;
	assign overflow_flag = s_q.ovr;
	assign controller_status = s_q.stat;
	assign int_n = s_q.int_n;
	assign buf_load = s_q.load;
	assign msg_error = s_q.msg_err;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	property p_first_load;
		go && acc0 && !s_q.rxif[0] |=> buf_load == 2'h1 && receive_flag[0] &&
			s_q.hit0 == $past(flt0_idx) && controller_status == STAT_BUF0;
	endproperty
	a_first_load: assert property (p_first_load) else $error("first buffer not loaded");

	property p_first_ovr;
		go && acc0 && s_q.rxif[0] && !s_q.roll_en |=> overflow_flag[0] && buf_load == 2'h0;
	endproperty
	a_first_ovr: assert property (p_first_ovr) else $error("first overflow missed");

	property p_rollover;
		go && acc0 && s_q.rxif[0] && s_q.roll_en && !s_q.rxif[1] |=> buf_load[1] &&
			s_q.hit1 == {ROLL_HIT_HI, $past(flt0_idx)};
	endproperty
	a_rollover: assert property (p_rollover) else $error("rollover not taken");

	property p_second_ovr;
		to1 && s_q.rxif[1] |=> overflow_flag[1] && !buf_load[1];
	endproperty
	a_second_ovr: assert property (p_second_ovr) else $error("second overflow missed");

	property p_discard;
		go && !acc0 && !acc1 |=> buf_load == 2'h0 &&
			overflow_flag == ($past(overflow_flag) & ~$past(ovr_flag_clear));
	endproperty
	a_discard: assert property (p_discard) else $error("rejected message stored");

	property p_second_load;
		go && !acc0 && acc1 && !s_q.rxif[1] |=> receive_flag[1] &&
			s_q.hit1 == $past(flt1_idx) && s_q.rtr1 == $past(msg_rtr);
	endproperty
	a_second_load: assert property (p_second_load) else $error("second load wrong");

	property p_invalid;
		s_q.state == PH_ASM && msg_end && !msg_valid |=> msg_error && buf_load == 2'h0
			##1 !msg_error;
	endproperty
	a_invalid: assert property (p_invalid) else $error("invalid message not flagged");

	property p_irq_level;
		receive_flag[0] && $past(receive_irq_enable[0]) |-> !int_n;
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("interrupt not held");

	property p_err_gate;
		overflow_flag != 2'h0 && receive_flag == 2'h0 |-> int_n == !$past(error_irq_enable);
	endproperty
	a_err_gate: assert property (p_err_gate) else $error("error interrupt gating wrong");

	property p_state_read;
		reg_rd && reg_addr == ADDR_PIN_CTRL && irq_mode[1] |=> !reg_rdata[PC_LVL_LSB + 1];
	endproperty
	a_state_read: assert property (p_state_read) else $error("state bit not masked");

	property p_idle_end;
		s_q.state == PH_IDLE && msg_end |=> buf_load == 2'h0 && !msg_error;
	endproperty
	a_idle_end: assert property (p_idle_end) else $error("end outside assembly acted on");

	property p_rx_irq;
		(to0 && receive_irq_enable[0]) ||
			(to1 && !s_q.rxif[1] && receive_irq_enable[1]) |=> !int_n;
	endproperty
	a_rx_irq: assert property (p_rx_irq) else $error("receive interrupt missing");

	property p_irq_quiet;
		receive_flag == 2'h0 && overflow_flag == 2'h0 |-> int_n;
	endproperty
	a_irq_quiet: assert property (p_irq_quiet) else $error("interrupt not released");

	property p_first_rtr;
		to0 |=> s_q.rtr0 == $past(msg_rtr);
	endproperty
	a_first_rtr: assert property (p_first_rtr) else $error("first remote bit wrong");

	property p_second_stat;
		to1 && !s_q.rxif[1] |=> controller_status == STAT_BUF1;
	endproperty
	a_second_stat: assert property (p_second_stat) else $error("status not second buffer");

	property p_copy_read;
		reg_rd && reg_addr == ADDR_CTRL0 |=>
			reg_rdata[CTL_ROLL_COPY_BIT] == reg_rdata[CTL_ROLL_BIT];
	endproperty
	a_copy_read: assert property (p_copy_read) else $error("rollover copy differs");

	property p_hit_readonly;
		reg_wr && reg_addr == ADDR_CTRL1 && !to1 |=>
			$stable(s_q.hit1) && $stable(s_q.rtr1);
	endproperty
	a_hit_readonly: assert property (p_hit_readonly) else $error("read-only bits written");

	property p_top_bits;
		reg_rd && reg_addr == ADDR_PIN_CTRL |=>
			(reg_rdata >> (PC_LVL_LSB + 2)) == 8'h00;
	endproperty
	a_top_bits: assert property (p_top_bits) else $error("unused pin control bits set");

	property p_load_flag;
		(buf_load & ~receive_flag) == 2'h0;
	endproperty
	a_load_flag: assert property (p_load_flag) else $error("load without receive flag");

	c_first: cover property (to0 ##1 buf_load[0]);
	c_roll: cover property (go && acc0 && s_q.rxif[0] && s_q.roll_en ##1 buf_load[1]);
	c_ovr: cover property (to1 && s_q.rxif[1]);
	c_err: cover property (msg_error);
	c_second: cover property (to1 && !s_q.rxif[1] ##1 buf_load[1]);
endmodule
`default_nettype wire

// File: tb/crbd_host_model.sv
// Host model: clears each receive flag a chosen number of cycles after it sees it set.
// Assumes sys_clk; it acts only while go is high, so the bench can hold flags set.
`timescale 1ns/10ps
`default_nettype none
module crbd_host_model (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic go,
	input wire logic [3:0] lat,
	input wire logic [1:0] receive_flag,
	output logic [1:0] rx_flag_clear
);
	logic [3:0] cnt [2];

	always @(posedge sys_clk or posedge rst) begin
		for (int i = 0; i < 2; i++) begin
			if (rst) begin
				cnt[i] <= 4'h0;
				rx_flag_clear[i] <= 1'b0;
			end else begin
				rx_flag_clear[i] <= 1'b0;
				if (!go || !receive_flag[i] || rx_flag_clear[i])
					cnt[i] <= 4'h0;
				else if (cnt[i] >= lat)
					rx_flag_clear[i] <= 1'b1;
				else
					cnt[i] <= cnt[i] + 4'h1;
			end
		end
	end
endmodule
`default_nettype wire

// File: tb/test_can_receive_buffer_dispatch.sv
// Testbench for the receive dispatch block: corner cases, then seeded random traffic.
// Assumes crbd_pkg, the design and the host model are compiled before it.
`timescale 1ns/10ps
`default_nettype none
module test_can_receive_buffer_dispatch;
	import crbd_pkg::*;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] reg_wmask = 8'h00;
	logic msg_start = 1'b0;
	logic msg_end = 1'b0;
	logic msg_valid = 1'b0;
	logic msg_rtr = 1'b0;
	logic flt0_match = 1'b0;
	logic flt0_idx = 1'b0;
	logic flt1_match = 1'b0;
	logic [2:0] flt1_idx = 3'h2;
	logic [1:0] ovr_flag_clear = 2'h0;
	logic [1:0] receive_irq_enable = 2'h3;
	logic error_irq_enable = 1'b1;
	logic go = 1'b0;
	logic [3:0] lat = 4'hf;
	logic [7:0] reg_rdata;
	logic [1:0] rx_flag_clear, receive_flag, overflow_flag, buf_load;
	logic [1:0] buf_full_pin_o, buf_full_pin_oe;
	logic [3:0] controller_status;
	logic int_n, msg_error;
	logic [1:0] e_rxf = 2'h0;
	logic [1:0] e_ovr = 2'h0;
	logic [7:0] pc = 8'h00;
	logic [7:0] c0 = 8'h00;
	logic [7:0] c1 = 8'h00;
	logic [3:0] e_stat = 4'h0;
	logic [2:0] e_hit1 = 3'h0;
	logic e_hit0 = 1'b0;
	logic e_rtr0 = 1'b0;
	logic e_rtr1 = 1'b0;
	logic [7:0] r;
	int seed = 32'h59bc;
	int n_errors = 0;
	int check_count = 0;
	int cycles = 0;

	crbd_top dut_u (.sys_clk, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_wmask,
		.reg_rdata, .msg_start, .msg_end, .msg_valid, .msg_rtr, .flt0_match, .flt0_idx,
		.flt1_match, .flt1_idx, .rx_flag_clear, .ovr_flag_clear, .receive_irq_enable,
		.error_irq_enable, .receive_flag, .overflow_flag, .controller_status, .int_n,
		.buf_load, .msg_error, .buf_full_pin_o, .buf_full_pin_oe);
	crbd_host_model host_u (.sys_clk, .rst, .go, .lat, .receive_flag, .rx_flag_clear);

	always #2.5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) e_rxf <= e_rxf & ~rx_flag_clear;

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			conclude();
		end
	end

	task automatic conclude();
		if (n_errors == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic cyc();
		@(posedge sys_clk);
		#1;
	endtask

	function automatic logic [7:0] rnd();
		return 8'($random(seed));
	endfunction

	function automatic logic [7:0] bm(input logic [7:0] o, input logic [7:0] d,
		input logic [7:0] m, input logic [7:0] w);
		return (o & ~(m & w)) | (d & m & w);
	endfunction

	function automatic logic irqn();
		return !((|(e_rxf & receive_irq_enable)) || (|e_ovr && error_irq_enable));
	endfunction

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [7:0] m);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		reg_wmask = m;
		cyc();
		reg_wr = 1'b0;
		if (a == ADDR_PIN_CTRL) pc = bm(pc, d, m, 8'h3f);
		if (a == ADDR_CTRL0) c0 = bm(c0, d, m, 8'h64);
		if (a == ADDR_CTRL1) c1 = bm(c1, d, m, 8'h60);
		cyc();
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		reg_rd = 1'b1;
		reg_addr = a;
		cyc();
		reg_rd = 1'b0;
		chk(reg_rdata, exp);
		cyc();
	endtask

	task automatic regs();
		rd(ADDR_PIN_CTRL, {2'h0, pc[5:4] & ~(pc[3:2] & pc[1:0]), pc[3:0]});
		rd(ADDR_CTRL0, c0 | {4'h0, e_rtr0, 1'b0, c0[2], e_hit0});
		rd(ADDR_CTRL1, c1 | {4'h0, e_rtr1, e_hit1});
	endtask

	task automatic pins();
		for (int i = 0; i < 2; i++) begin
			chk(buf_full_pin_oe[i], pc[2 + i]);
			if (pc[2 + i]) chk(buf_full_pin_o[i], pc[i] ? !e_rxf[i] : pc[4 + i]);
		end
	endtask

	task automatic oclr(input logic [1:0] m);
		ovr_flag_clear = m;
		cyc();
		ovr_flag_clear = 2'h0;
		e_ovr = e_ovr & ~m;
		cyc();
	endtask

	task automatic msg(input logic v, input logic rt, input logic f0, input logic i0,
		input logic f1, input logic [2:0] i1);
		logic m0;
		logic m1;
		logic [1:0] ld;
		logic [1:0] ov;
		go = 1'b0;
		cyc();
		msg_start = 1'b1;
		cyc();
		msg_start = 1'b0;
		msg_end = 1'b1;
		msg_valid = v;
		msg_rtr = rt;
		flt0_match = f0;
		flt0_idx = i0;
		flt1_match = f1;
		flt1_idx = i1;
		m0 = v & (f0 | c0[6:5] == FMODE_ANY);
		m1 = v & (f1 | c1[6:5] == FMODE_ANY);
		ld = 2'h0;
		ov = 2'h0;
		if (m0 && !e_rxf[0]) ld = 2'h1;
		else if (m0 && !c0[2]) ov = 2'h1;
		else if ((m0 || m1) && e_rxf[1]) ov = 2'h2;
		else if (m0 || m1) ld = 2'h2;
		cyc();
		msg_end = 1'b0;
		e_rxf = e_rxf | ld;
		e_ovr = e_ovr | ov;
		if (ld[0]) begin
			e_hit0 = i0;
			e_rtr0 = rt;
			e_stat = STAT_BUF0;
		end
		if (ld[1]) begin
			e_rtr1 = rt;
			e_hit1 = m0 ? {ROLL_HIT_HI, i0} : i1;
			if (m0) e_hit0 = i0;
			e_stat = STAT_BUF1;
		end
		chk(buf_load, ld);
		chk(receive_flag, e_rxf);
		chk(overflow_flag, e_ovr);
		chk(msg_error, !v);
		chk(controller_status, e_stat);
		chk(int_n, irqn());
		cyc();
		chk(buf_load, 8'h00);
		pins();
		if (m0 == f0 && m1 == f1) regs();
		go = 1'b1;
	endtask

	initial begin
		repeat (5) cyc();
		rst = 1'b0;
		chk(int_n, 8'h01);
		pins();
		regs();
		rd(8'h0d, 8'h00);
		wr(8'h0d, 8'hff, 8'hff);
		wr(ADDR_CTRL0, 8'hff, 8'hff);
		wr(ADDR_CTRL1, 8'hff, 8'hff);
		regs();
		wr(ADDR_CTRL0, 8'h00, 8'h60);
		wr(ADDR_CTRL1, 8'h00, 8'hff);
		wr(ADDR_PIN_CTRL, 8'h0f, 8'h0f);
		msg(1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 3'h2);
		msg(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 3'h5);
		msg(1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 3'h3);
		wr(ADDR_CTRL0, 8'h00, 8'h04);
		msg(1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 3'h2);
		msg(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 3'h2);
		oclr(2'h3);
		lat = 4'h0;
		go = 1'b1;
		repeat (4) cyc();
		msg(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 3'h4);
		msg(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 3'h2);
		wr(ADDR_PIN_CTRL, 8'h30, 8'h33);
		pins();
		regs();
		repeat (250) begin
			r = rnd();
			lat = r[3:0];
			receive_irq_enable = r[5:4];
			error_irq_enable = r[6];
			if (r[7]) wr(ADDR_CTRL0, rnd(), 8'h64);
			r = rnd();
			if (r[2:0] == 3'h0) wr(ADDR_PIN_CTRL, rnd(), rnd());
			if (r[5:3] == 3'h0) oclr(r[7:6]);
			repeat (r[7:4]) cyc();
			r = rnd();
			msg(r[7:5] != 3'h0, r[0], r[1], r[2], r[3], 3'h2 + {1'b0, r[5:4]});
		end
		lat = 4'h0;
		oclr(2'h3);
		repeat (4) cyc();
		lat = 4'hf;
		wr(ADDR_CTRL0, 8'h60, 8'h60);
		msg(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 3'h2);
		wr(ADDR_CTRL0, 8'h00, 8'h60);
		wr(ADDR_CTRL1, 8'h60, 8'h60);
		msg(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 3'h2);
		conclude();
	end
endmodule
`default_nettype wire
